// >>> fpc_pkg.sv
package fpc_pkg;
	localparam int          FW_W      = 18;
	localparam int          NWORDS    = 4;
	localparam int          OFS_W     = 10;
	// register offsets on the serial configuration port
	localparam logic [4:0]  A_FCA     = 5'h00;
	localparam logic [4:0]  A_FW_LO   = 5'h01;
	localparam logic [4:0]  A_FW_HI   = 5'h08;
	localparam logic [4:0]  A_FSK     = 5'h09;
	localparam logic [4:0]  A_AMPLITUDE_SETTING_ZERO   = 5'h0a;
	localparam logic [4:0]  A_AMPLITUDE_SETTING_ONE   = 5'h0b;
	localparam logic [4:0]  A_ACON2   = 5'h0c;
	localparam logic [4:0]  A_MODULATION_RAMP_CONTROL   = 5'h0d;
	localparam logic [4:0]  A_TRANSMITTER_CONTROL   = 5'h0e;
	// transmitter_control fields
	localparam int          TX_PLL    = 0;
	localparam int          TX_XR     = 1;
	localparam int          TX_PAM    = 2;
	localparam int          TX_BAND   = 4;
	localparam int          TX_XDIV   = 5;
	localparam int          TX_CKDIS  = 6;
	localparam int          TX_PD     = 7;
	// amplitude register fields, ramp register mask and register reset value
	localparam int          AC_ASK    = 7;
	localparam int          A2_BROWNOUT_ENABLE   = 5;
	localparam int          A2_ADAPTIVE_REGULATOR_ENABLE  = 6;
	localparam logic [7:0]  MR_MASK   = 8'h7f;
	localparam logic [7:0]  REG_RST   = 8'h00;
	// 1/16384 of f_ref equals two synthesizer steps of f_ref/32768
	localparam int          DEV_SCALE = 2;
	typedef enum logic {ST_IDLE, ST_TX} fpc_tx_t;
endpackage : fpc_pkg

// >>> fpc_sync2.sv
module fpc_sync2
	import fpc_pkg::*;
(
	input  wire logic i_sys_clk,
	input  wire logic i_rst_n,
	input  wire logic i_d,
	output logic      o_q
);
	typedef struct packed {
		logic s1;
		logic s2;
	} fpc_sync_st_t;

	fpc_sync_st_t r;
	fpc_sync_st_t n;

	always_comb begin
		n    = r;
		n.s1 = i_d;
		n.s2 = r.s1;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign o_q = r.s2;
endmodule : fpc_sync2

// >>> fpc_ramp.sv
module fpc_ramp
	import fpc_pkg::*;
(
	input  wire logic                    i_sys_clk,
	input  wire logic                    i_rst_n,
	input  wire logic                    i_run,
	input  wire logic                    i_data,
	input  wire logic [7:0]              i_dev,
	input  wire logic [6:0]              i_rmp,
	input  wire logic                    i_band,
	output logic signed [OFS_W-1:0]      o_offset
);
	typedef struct packed {
		logic signed [OFS_W-1:0] ofs;
		logic [7:0]              cnt;
	} fpc_ramp_st_t;

	fpc_ramp_st_t            r;
	fpc_ramp_st_t            n;
	logic signed [OFS_W-1:0] tgt;
	logic [7:0]              ivl;

	// low band doubles the interval: the ramp time scales with (2 - band)
	assign ivl = i_band ? {1'b0, i_rmp} : {i_rmp, 1'b0};
	assign tgt = i_data ? $signed({1'b0, i_dev, 1'b0}) : -$signed({1'b0, i_dev, 1'b0});

	always_comb begin
		n = r;
		if (!i_run) begin
			n.ofs = '0;
			n.cnt = '0;
		end else if (i_rmp == 7'h00) begin
			n.ofs = tgt;
			n.cnt = '0;
		end else if (r.ofs == tgt) begin
			n.cnt = '0;
		end else if (r.cnt + 8'h01 >= ivl) begin
			n.cnt = '0;
			// steps of two land exactly on the even target
			n.ofs = (r.ofs < tgt) ? r.ofs + OFS_W'(DEV_SCALE)
				: r.ofs - OFS_W'(DEV_SCALE);
		end else begin
			n.cnt = r.cnt + 8'h01;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign o_offset = r.ofs;

	property p_hard_fsk;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_run && i_rmp == 7'h00 |=> o_offset == $past(tgt);
	endproperty
	a_hard_fsk: assert property (p_hard_fsk) else $error("hard fsk missed target");

	property p_soft_step;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_run && $past(i_run) && i_rmp != 7'h00 |->
			o_offset - $past(o_offset) inside {-2, 0, 2};
	endproperty
	a_soft_step: assert property (p_soft_step) else $error("soft fsk jumped");
endmodule : fpc_ramp

// >>> fpc_ctrl.sv
module fpc_ctrl
	import fpc_pkg::*;
(
	input  wire logic               i_sys_clk,
	input  wire logic               i_rst_n,
	input  wire logic               i_reg_wr,
	input  wire logic [4:0]         i_reg_addr,
	input  wire logic [7:0]         i_reg_wdata,
	output logic [7:0]              o_reg_rdata,
	input  wire logic               i_cmd_valid,
	input  wire logic               i_cmd_start,
	input  wire logic               i_cmd_d,
	input  wire logic               i_cmd_e,
	input  wire logic               i_cmd_f,
	input  wire logic               i_tx_data,
	input  wire logic               i_supply_low,
	output logic                    o_pa_enable,
	output logic                    o_synth_enable,
	output logic                    o_power_down,
	output logic                    o_clock_output_disable,
	output logic                    o_ref_div2,
	output logic                    o_pa_at_vco,
	output logic [1:0]              o_amplifier_power_mode,
	output logic                    o_osc_regulated,
	output logic                    o_regulator_adaptive,
	output logic                    o_fsk_mode,
	output logic [3:0]              o_amp_level,
	output logic [FW_W-1:0]         o_freq_word,
	output logic signed [OFS_W-1:0] o_fsk_offset
);
	typedef struct packed {
		fpc_tx_t               st;
		logic [7:0]            fca;
		logic [NWORDS-1:0][7:0] fch;
		logic [NWORDS-1:0][7:0] fcl;
		logic [7:0]            fsk;
		logic [7:0]            amplitude_setting_zero;
		logic [7:0]            amplitude_setting_one;
		logic [7:0]            acon2;
		logic [7:0]            modulation_ramp_control;
		logic [7:0]            transmitter_control;
		logic                  sel_d;
		logic [1:0]            sel_ef;
		logic                  osc_unreg;
		logic [7:0]            rdata;
	} fpc_ctrl_st_t;

	fpc_ctrl_st_t r;
	fpc_ctrl_st_t n;
	logic         rst_n;
	logic         low_s;
	logic         tx_on;
	logic         bo;
	logic         ask_sel;

	// word index of a frequency byte address; odd addresses hold high bytes
	function automatic logic [1:0] fw_slot(input logic [4:0] a);
		logic [4:0] t;
		t = a - A_FW_LO;
		return t[2:1];
	endfunction : fw_slot

	function automatic logic is_fw(input logic [4:0] a);
		return a >= A_FW_LO && a <= A_FW_HI;
	endfunction : is_fw

	function automatic logic [FW_W-1:0] fword(input fpc_ctrl_st_t s,
			input logic [1:0] k);
		logic [7:0] top;
		top = s.fca >> {k, 1'b0};
		return {top[1:0], s.fch[k], s.fcl[k]};
	endfunction : fword

	fpc_sync2 u_rst_sync (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.i_d       (1'b1),
		.o_q       (rst_n)
	);

	// the comparator is asynchronous to the reference clock
	fpc_sync2 u_low_sync (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (rst_n),
		.i_d       (i_supply_low),
		.o_q       (low_s)
	);

	assign tx_on = r.st == ST_TX;
	// regulator mode plays no part: both modes are protected alike
	assign bo = tx_on && r.acon2[A2_BROWNOUT_ENABLE] && low_s;
	assign ask_sel = r.sel_d ? r.amplitude_setting_one[AC_ASK] : r.amplitude_setting_zero[AC_ASK];

	always_comb begin
		n = r;
		if (i_reg_wr) begin
			if (is_fw(i_reg_addr)) begin
				if (i_reg_addr[0]) begin
					n.fch[fw_slot(i_reg_addr)] = i_reg_wdata;
				end else begin
					n.fcl[fw_slot(i_reg_addr)] = i_reg_wdata;
				end
			end
			case (i_reg_addr)
				A_FCA: begin
					n.fca = i_reg_wdata;
				end
				A_FSK: begin
					n.fsk = i_reg_wdata;
				end
				A_AMPLITUDE_SETTING_ZERO: begin
					n.amplitude_setting_zero = i_reg_wdata;
				end
				A_AMPLITUDE_SETTING_ONE: begin
					n.amplitude_setting_one = i_reg_wdata;
				end
				A_ACON2: begin
					n.acon2 = i_reg_wdata;
				end
				A_MODULATION_RAMP_CONTROL: begin
					n.modulation_ramp_control = i_reg_wdata & MR_MASK;
				end
				A_TRANSMITTER_CONTROL: begin
					n.transmitter_control = i_reg_wdata;
					n.osc_unreg = 1'b0;
				end
				default: begin
				end
			endcase
		end
		if (i_cmd_valid) begin
			if (i_cmd_start) begin
				n.st = ST_TX;
				n.sel_d = i_cmd_d;
				n.sel_ef = {i_cmd_f, i_cmd_e};
			end else begin
				n.st = ST_IDLE;
			end
		end
		// a power fail overrides a same-cycle start and a same-cycle write of the PLL bit
		if (bo) begin
			n.st = ST_IDLE;
			n.transmitter_control[TX_PLL] = 1'b0;
			// enables in acon2 are left untouched so software sees them
			if (r.transmitter_control[TX_XR] && r.acon2[A2_ADAPTIVE_REGULATOR_ENABLE]) begin
				n.osc_unreg = 1'b1;
			end
		end
		case (i_reg_addr)
			A_FCA: begin
				n.rdata = r.fca;
			end
			A_FSK: begin
				n.rdata = r.fsk;
			end
			A_AMPLITUDE_SETTING_ZERO: begin
				n.rdata = r.amplitude_setting_zero;
			end
			A_AMPLITUDE_SETTING_ONE: begin
				n.rdata = r.amplitude_setting_one;
			end
			A_ACON2: begin
				n.rdata = r.acon2;
			end
			A_MODULATION_RAMP_CONTROL: begin
				n.rdata = r.modulation_ramp_control;
			end
			A_TRANSMITTER_CONTROL: begin
				n.rdata = r.transmitter_control;
			end
			default: begin
				if (is_fw(i_reg_addr)) begin
					n.rdata = i_reg_addr[0] ? r.fch[fw_slot(i_reg_addr)]
						: r.fcl[fw_slot(i_reg_addr)];
				end else begin
					n.rdata = 8'h00;
				end
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '{st: ST_IDLE, fca: REG_RST, fch: '0, fcl: '0, fsk: REG_RST,
				amplitude_setting_zero: REG_RST, amplitude_setting_one: REG_RST, acon2: REG_RST, modulation_ramp_control: REG_RST,
				transmitter_control: REG_RST, sel_d: 1'b0, sel_ef: 2'b00, osc_unreg: 1'b0,
				rdata: 8'h00};
		end else begin
			r <= n;
		end
	end

	fpc_ramp u_ramp (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (rst_n),
		.i_run     (o_fsk_mode),
		.i_data    (i_tx_data),
		.i_dev     (r.fsk),
		.i_rmp     (r.modulation_ramp_control[6:0]),
		.i_band    (r.transmitter_control[TX_BAND]),
		.o_offset  (o_fsk_offset)
	);

	assign o_reg_rdata            = r.rdata;
	assign o_pa_enable            = tx_on;
	assign o_synth_enable         = r.transmitter_control[TX_PLL];
	assign o_power_down           = r.transmitter_control[TX_PD];
	assign o_clock_output_disable = r.transmitter_control[TX_CKDIS];
	assign o_ref_div2             = r.transmitter_control[TX_XDIV];
	assign o_pa_at_vco            = r.transmitter_control[TX_BAND];
	assign o_amplifier_power_mode = r.transmitter_control[TX_PAM+1:TX_PAM];
	// fixed mode leaves the oscillator supply where software put it
	assign o_osc_regulated        = r.transmitter_control[TX_XR] & ~r.osc_unreg;
	assign o_regulator_adaptive   = r.acon2[A2_ADAPTIVE_REGULATOR_ENABLE];
	assign o_fsk_mode             = tx_on && !ask_sel;
	assign o_amp_level            = r.sel_d ? r.amplitude_setting_one[3:0] : r.amplitude_setting_zero[3:0];
	// word feeds the analogue synthesizer: f = ref*((w+0.5)/32768+65)
	assign o_freq_word            = fword(r, r.sel_ef);

	sequence s_fail;
		tx_on && r.acon2[A2_BROWNOUT_ENABLE] && low_s;
	endsequence

	property p_fail_stop;
		@(posedge i_sys_clk) disable iff (!rst_n)
		s_fail |=> !o_pa_enable && !o_synth_enable;
	endproperty
	a_fail_stop: assert property (p_fail_stop) else $error("no shutdown on fail");

	property p_fail_keep;
		@(posedge i_sys_clk) disable iff (!rst_n)
		s_fail ##0 !i_reg_wr |=> r.acon2[A2_BROWNOUT_ENABLE] && $stable(o_regulator_adaptive);
	endproperty
	a_fail_keep: assert property (p_fail_keep) else $error("enables lost on fail");

	property p_fail_off;
		@(posedge i_sys_clk) disable iff (!rst_n)
		tx_on && !r.acon2[A2_BROWNOUT_ENABLE] && !i_cmd_valid |=> o_pa_enable;
	endproperty
	a_fail_off: assert property (p_fail_off) else $error("detection while disabled");

	property p_idle_none;
		@(posedge i_sys_clk) disable iff (!rst_n)
		!tx_on && !i_reg_wr |=> $stable(o_synth_enable) && $stable(o_osc_regulated);
	endproperty
	a_idle_none: assert property (p_idle_none) else $error("fail acted while idle");

	property p_fail_cause;
		@(posedge i_sys_clk) disable iff (!rst_n)
		$fell(o_pa_enable) && !$past(i_cmd_valid) |-> $past(low_s)
			&& $past(i_supply_low, 3);
	endproperty
	a_fail_cause: assert property (p_fail_cause) else $error("unsynced shutdown");

	property p_osc_fall;
		@(posedge i_sys_clk) disable iff (!rst_n)
		s_fail ##0 (r.transmitter_control[TX_XR] && r.acon2[A2_ADAPTIVE_REGULATOR_ENABLE]) |=> !o_osc_regulated;
	endproperty
	a_osc_fall: assert property (p_osc_fall) else $error("oscillator kept regulated");

	property p_osc_fixed;
		@(posedge i_sys_clk) disable iff (!rst_n)
		s_fail ##0 (!r.acon2[A2_ADAPTIVE_REGULATOR_ENABLE] && !i_reg_wr) |=> $stable(o_osc_regulated);
	endproperty
	a_osc_fixed: assert property (p_osc_fixed) else $error("fixed mode osc changed");

	property p_word_sel;
		@(posedge i_sys_clk) disable iff (!rst_n)
		i_cmd_valid && i_cmd_start && !i_reg_wr |=>
			o_freq_word == fword(r, {$past(i_cmd_f), $past(i_cmd_e)});
	endproperty
	a_word_sel: assert property (p_word_sel) else $error("wrong frequency word");

	property p_fsk_sel;
		@(posedge i_sys_clk) disable iff (!rst_n)
		i_cmd_valid && i_cmd_start && !bo |=> o_pa_enable
			&& o_fsk_mode == !($past(i_cmd_d) ? r.amplitude_setting_one[AC_ASK] : r.amplitude_setting_zero[AC_ASK]);
	endproperty
	a_fsk_sel: assert property (p_fsk_sel) else $error("fsk with ask bit set");
endmodule : fpc_ctrl

// >>> fpc_host_model.sv
module fpc_host_model
	import fpc_pkg::*;
(
	input  wire logic  i_sys_clk,
	output logic       o_reg_wr,
	output logic [4:0] o_reg_addr,
	output logic [7:0] o_reg_wdata,
	output logic       o_cmd_valid,
	output logic       o_cmd_start,
	output logic [2:0] o_cmd_fed
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		o_reg_wr    = 1'b0;
		o_reg_addr  = 5'h00;
		o_reg_wdata = 8'h00;
		o_cmd_valid = 1'b0;
		o_cmd_start = 1'b0;
		o_cmd_fed   = 3'h0;
	end

	// callers keep words at or below 163839
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		o_reg_wr    <= 1'b1;
		o_reg_addr  <= a;
		o_reg_wdata <= d;
		@(posedge i_sys_clk);
		o_reg_wr    <= 1'b0;
		// idle data must not look like the byte just written
		o_reg_wdata <= ~d;
	endtask : wr

	task automatic rd(input logic [4:0] a);
		@(posedge i_sys_clk);
		o_reg_addr <= a;
		@(posedge i_sys_clk);
		@(negedge i_sys_clk);
	endtask : rd

	// fed is {f, e, d}
	task automatic cmd(input logic s, input logic [2:0] fed);
		@(posedge i_sys_clk);
		o_cmd_valid <= 1'b1;
		o_cmd_start <= s;
		o_cmd_fed   <= fed;
		@(posedge i_sys_clk);
		o_cmd_valid <= 1'b0;
	endtask : cmd
endmodule : fpc_host_model

// >>> fpc_ctrl_tb.sv
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
	$display("[ERR] %0t got %h exp %h", $time, a, e); end end

module fpc_ctrl_tb
	import fpc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic                    i_sys_clk, i_rst_n, i_reg_wr, i_cmd_valid, i_cmd_start;
	logic                    i_tx_data, i_supply_low, o_pa_enable, o_synth_enable;
	logic                    o_power_down, o_clock_output_disable, o_ref_div2, o_pa_at_vco;
	logic                    o_osc_regulated, o_regulator_adaptive, o_fsk_mode;
	logic [1:0]              o_amplifier_power_mode;
	logic [2:0]              fed;
	logic [3:0]              o_amp_level;
	logic [4:0]              i_reg_addr;
	logic [7:0]              i_reg_wdata, o_reg_rdata;
	logic [FW_W-1:0]         o_freq_word;
	logic signed [OFS_W-1:0] o_fsk_offset, prev;
	int                      fails, check_count, n;
	logic [7:0]              tv [2]  = '{8'hb5, 8'h4a};
	logic [7:0]              ac2 [4] = '{8'h60, 8'h20, 8'h40, 8'h60};
	logic [7:0]              txv [4] = '{8'h02, 8'h02, 8'h03, 8'h03};
	logic [2:0]              xo [4]  = '{3'b000, 3'b001, 3'b111, 3'b011};
	logic [17:0]             wv [4]  = '{18'h27fff, 18'h1a5c3, 18'h0ff00, 18'h00001};

	fpc_ctrl DUT (
		.i_sys_clk, .i_rst_n, .i_reg_wr, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
		.i_cmd_valid, .i_cmd_start, .i_cmd_d(fed[0]), .i_cmd_e(fed[1]), .i_cmd_f(fed[2]),
		.i_tx_data, .i_supply_low, .o_pa_enable, .o_synth_enable, .o_power_down,
		.o_clock_output_disable, .o_ref_div2, .o_pa_at_vco, .o_amplifier_power_mode,
		.o_osc_regulated, .o_regulator_adaptive, .o_fsk_mode, .o_amp_level, .o_freq_word,
		.o_fsk_offset
	);

	fpc_host_model host (
		.i_sys_clk, .o_reg_wr(i_reg_wr), .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata),
		.o_cmd_valid(i_cmd_valid), .o_cmd_start(i_cmd_start), .o_cmd_fed(fed)
	);

	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end

	task automatic results();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results

	task automatic rchk(input logic [4:0] a, input logic [7:0] e);
		host.rd(a);
		`CHK(o_reg_rdata, e)
	endtask : rchk

	// bounded wait; the offset must never move away from the target meanwhile
	task automatic wait_off(input logic signed [OFS_W-1:0] e, output int cnt);
		cnt = 0;
		prev = o_fsk_offset;
		do begin
			@(negedge i_sys_clk);
			cnt++;
			`CHK((e > 0) ? o_fsk_offset < prev : o_fsk_offset > prev, 1'b0)
			prev = o_fsk_offset;
		end while (o_fsk_offset !== e && cnt < 100);
		if (cnt >= 100) begin
			fails++;
			results();
		end
	endtask : wait_off

	initial begin
		i_rst_n      = 1'b0;
		i_tx_data    = 1'b0;
		i_supply_low = 1'b0;
		fails        = 0;
		check_count  = 0;
		repeat (5) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		repeat (3) @(posedge i_sys_clk);
		host.wr(5'h1f, 8'hff);
		for (int a = 0; a < 15; a++) begin
			rchk(5'(a), REG_RST);
		end
		rchk(5'h1f, 8'h00);
		host.wr(A_MODULATION_RAMP_CONTROL, 8'hff);
		rchk(A_MODULATION_RAMP_CONTROL, MR_MASK);
		foreach (tv[i]) begin
			host.wr(A_TRANSMITTER_CONTROL, tv[i]);
			@(negedge i_sys_clk);
			`CHK({o_power_down, o_clock_output_disable, o_ref_div2, o_pa_at_vco,
				o_amplifier_power_mode, o_osc_regulated, o_synth_enable}, tv[i])
			rchk(A_TRANSMITTER_CONTROL, tv[i]);
		end
		$display("test control register done");
		host.wr(A_FCA, {wv[3][17:16], wv[2][17:16], wv[1][17:16], wv[0][17:16]});
		for (int k = 0; k < 4; k++) begin
			host.wr(A_FW_LO + 5'(2 * k), wv[k][15:8]);
			host.wr(A_FW_LO + 5'(2 * k + 1), wv[k][7:0]);
		end
		for (int k = 0; k < 4; k++) begin
			host.cmd(1'b1, {k[1:0], 1'b0});
			@(negedge i_sys_clk);
			`CHK(o_freq_word, wv[k])
		end
		host.cmd(1'b0, 3'b000);
		$display("test frequency words done");
		host.wr(A_AMPLITUDE_SETTING_ZERO, 8'h05);
		host.wr(A_AMPLITUDE_SETTING_ONE, 8'h8a);
		host.cmd(1'b1, 3'b000);
		@(negedge i_sys_clk);
		`CHK({o_fsk_mode, o_amp_level}, 5'h15)
		host.cmd(1'b1, 3'b001);
		@(negedge i_sys_clk);
		`CHK({o_fsk_mode, o_amp_level}, 5'h0a)
		host.cmd(1'b0, 3'b000);
		@(negedge i_sys_clk);
		`CHK({o_pa_enable, o_fsk_mode}, 2'b00)
		$display("test modulation select done");
		host.wr(A_FSK, 8'h03);
		for (int b = 0; b < 2; b++) begin
			host.wr(A_TRANSMITTER_CONTROL, 8'(b * 16 + 1));
			host.wr(A_MODULATION_RAMP_CONTROL, 8'h02);
			i_tx_data <= 1'b1;
			host.cmd(1'b1, 3'b000);
			wait_off(10'sd6, n);
			`CHK(o_fsk_offset, 10'sd6)
			@(posedge i_sys_clk);
			i_tx_data <= 1'b0;
			wait_off(-10'sd6, n);
			`CHK(n >= 12 * (2 - b) - 2 && n <= 12 * (2 - b) + 2, 1'b1)
		end
		host.wr(A_MODULATION_RAMP_CONTROL, 8'h00);
		i_tx_data <= 1'b1;
		repeat (2) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
		`CHK(o_fsk_offset, 10'sd6)
		host.cmd(1'b0, 3'b000);
		// the fsk offset clears one cycle after transmission stops
		@(posedge i_sys_clk);
		@(negedge i_sys_clk);
		`CHK(o_fsk_offset, 10'sd0)
		$display("test soft fsk done");
		// rewriting the regulator bits before the synthesizer restarts is what a host must do
		for (int i = 0; i < 4; i++) begin
			host.wr(A_ACON2, ac2[i]);
			host.wr(A_TRANSMITTER_CONTROL, 8'h03);
			if (i < 3) begin
				host.cmd(1'b1, 3'b000);
			end
			@(posedge i_sys_clk);
			i_supply_low <= 1'b1;
			// two synchroniser stages: still on just before the shutdown edge
			repeat (2) @(posedge i_sys_clk);
			@(negedge i_sys_clk);
			`CHK(o_pa_enable, i < 3)
			repeat (2) @(posedge i_sys_clk);
			@(negedge i_sys_clk);
			`CHK({o_pa_enable, o_synth_enable, o_osc_regulated}, xo[i])
			`CHK(o_regulator_adaptive, ac2[i][6])
			rchk(A_ACON2, ac2[i]);
			rchk(A_TRANSMITTER_CONTROL, txv[i]);
			@(posedge i_sys_clk);
			i_supply_low <= 1'b0;
			host.cmd(1'b0, 3'b000);
		end
		$display("test brown-out done");
		results();
	end
endmodule : fpc_ctrl_tb
